// [shared/wwdc_defs.svh]
`ifndef WWDC_DEFS_SVH
`define WWDC_DEFS_SVH
// ----------------------------------------
// Register map
// ----------------------------------------
`define WWDC_ADDR_W 8
`define WWDC_ADDR_CTRL 8'h00
`define WWDC_ADDR_CFG 8'h01
`define WWDC_ADDR_STAT 8'h02
`define WWDC_ADDR_TMIN 8'h03
`define WWDC_ADDR_TMAX 8'h04
`define WWDC_CTRL_RST 8'h7F
`define WWDC_ACT_BIT 7
`define WWDC_TOP_BIT 6
`define WWDC_CNT_TOP 7'h40
// ----------------------------------------
// Timing
// ----------------------------------------
`define WWDC_PRESC_PERIODS 16384
`define WWDC_PRESC_W 14
`define WWDC_CLK_MHZ 40
`define WWDC_RST_PULSE_NS 500
`define WWDC_RST_CYC ((`WWDC_RST_PULSE_NS * `WWDC_CLK_MHZ + 999) / 1000)
`define WWDC_MIN_OFFS 128
`define WWDC_ADJ_OFFS 192
`define WWDC_LSB_MUL 64
// ----------------------------------------
// Timebase constants
// ----------------------------------------
`define WWDC_TB0_HIGH 7'h04
`define WWDC_TB0_LOW 7'h3B
`define WWDC_TB1_HIGH 7'h08
`define WWDC_TB1_LOW 7'h35
`define WWDC_TB2_HIGH 7'h14
`define WWDC_TB2_LOW 7'h23
`define WWDC_TB3_HIGH 7'h31
`define WWDC_TB3_LOW 7'h36
`endif

// [shared/wwdc_pkg.sv]
package wwdc_pkg;
   typedef enum logic [1:0]
   {
      WWDC_TB_2MS = 2'b00,
      WWDC_TB_4MS = 2'b01,
      WWDC_TB_10MS = 2'b10,
      WWDC_TB_25MS = 2'b11
   } wwdc_tb_e;
   typedef enum logic [0:0]
   {
      WWDC_ST_RUN = 1'b0,
      WWDC_ST_PULSE = 1'b1
   } wwdc_state_e;
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wwdc_bus_s;
   typedef struct packed
   {
      logic [6:0] high_c;
      logic [6:0] low_c;
   } wwdc_tbconst_s;
endpackage

// [rtl/wwdc_watchdog.sv]
// Behaviour
// [RULE_01] Counter decrements once every 16384 divided oscillator clocks.
// [RULE_02] Six low counter bits give 64 timeout steps.
// [RULE_03] Active and top bit clearing starts a reset pulse of about 500ns.
// [RULE_04] Counter runs even when inactive; only reset is gated.
// [RULE_05] Software reloads with FFh..C0h regularly to avoid reset.
// [RULE_06] Inactive after reset; once active stays active until reset.
// [RULE_07] Write with activate set and top bit clear forces a reset.
// [RULE_08] HALT while active causes a device reset.
// [RULE_09] Prescaler phase unknown at write; timeout lies between min and max.
// [RULE_10] Timebase constants: 4/59, 8/53, 20/35, 49/54.
// [RULE_11] Timebase select 00=2ms, 01=4ms, 10=10ms, 11=25ms.
// [RULE_12] Minimum timeout formula with 128 and 192 offsets.
// [RULE_13] Maximum timeout formula starting from 16384 periods.
// [RULE_14] Divisions in timeout formulas truncate downward.
// [RULE_15] Options: HALT triggers reset; permanently enabled hardware watchdog.
// [RULE_16] Hardware watchdog option forces active; activation bit ignored.
// [RULE_17] Control register resets to 7Fh.
// [RULE_18] Write loads seven counter bits and restarts the prescaler.
`include "wwdc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module wwdc_watchdog
   import wwdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic osc2_tick,
   input wire logic halt_exec,
   input wire logic [7:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [7:0] bus_rdata,
   output logic reset_out_n,
   output logic watchdog_active
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic tick_s1_q, tick_s2_q, tick_s3_q;
   logic halt_s1_q, halt_s2_q, halt_s3_q;
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_s1_q <= 1'b0;
         tick_s2_q <= 1'b0;
         tick_s3_q <= 1'b0;
         halt_s1_q <= 1'b0;
         halt_s2_q <= 1'b0;
         halt_s3_q <= 1'b0;
      end
      else
      begin
         tick_s1_q <= osc2_tick;
         tick_s2_q <= tick_s1_q;
         tick_s3_q <= tick_s2_q;
         halt_s1_q <= halt_exec;
         halt_s2_q <= halt_s1_q;
         halt_s3_q <= halt_s2_q;
      end
   end
   // Rising edges of the divided clock and of the HALT strobe
   logic osc_edge, halt_edge;
   assign osc_edge = tick_s2_q & ~tick_s3_q;
   assign halt_edge = halt_s2_q & ~halt_s3_q;

   wwdc_bus_s bus;
   assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

   // ----------------------------------------
   // Control, prescaler and reset pulse
   // ----------------------------------------
   logic act_q, act_d;
   logic [6:0] cnt_q, cnt_d;
   logic [`WWDC_PRESC_W-1:0] presc_q, presc_d;
   logic halt_opt_q, halt_opt_d;
   logic hw_opt_q, hw_opt_d;
   logic [1:0] tb_q, tb_d;
   logic wdg_rst_q, wdg_rst_d;
   wwdc_state_e st_q, st_d;
   logic [4:0] pulse_q, pulse_d;
   logic reset_n_q, reset_n_d;
   logic eff_act, ctrl_wr, cfg_wr, trip;

   assign eff_act = act_q | hw_opt_q; // [RULE_16]
   assign ctrl_wr = bus.wr && (bus.addr == `WWDC_ADDR_CTRL);
   assign cfg_wr = bus.wr && (bus.addr == `WWDC_ADDR_CFG);

   always_comb
   begin
      act_d = act_q;
      cnt_d = cnt_q;
      presc_d = presc_q;
      halt_opt_d = halt_opt_q;
      hw_opt_d = hw_opt_q;
      tb_d = tb_q;
      wdg_rst_d = wdg_rst_q;
      st_d = st_q;
      pulse_d = pulse_q;
      reset_n_d = reset_n_q;
      trip = 1'b0;
      if (cfg_wr)
      begin
         halt_opt_d = bus.wdata[0]; // [RULE_15]
         hw_opt_d = hw_opt_q | bus.wdata[1]; // [RULE_15]
         tb_d = bus.wdata[3:2]; // [RULE_11]
      end
      if (ctrl_wr)
      begin
         // Activation is sticky; software can only set it
         act_d = act_q | bus.wdata[`WWDC_ACT_BIT]; // [RULE_06]
         cnt_d = bus.wdata[6:0]; // [RULE_18] [RULE_02]
         presc_d = '0; // [RULE_18] [RULE_09]
         if ((bus.wdata[`WWDC_ACT_BIT] | act_q | hw_opt_q) && !bus.wdata[`WWDC_TOP_BIT])
            trip = 1'b1; // [RULE_07]
      end
      else if (osc_edge)
      begin
         // Free running regardless of activation
         if (presc_q == `WWDC_PRESC_W'(`WWDC_PRESC_PERIODS - 1)) // [RULE_01]
         begin
            presc_d = '0;
            cnt_d = cnt_q - 7'h01; // [RULE_04]
            if (cnt_q == `WWDC_CNT_TOP && eff_act)
               trip = 1'b1; // [RULE_03]
         end
         else
            presc_d = presc_q + `WWDC_PRESC_W'(1);
      end
      if (halt_edge && eff_act && halt_opt_q)
         trip = 1'b1; // [RULE_08]
      unique case (st_q)
         WWDC_ST_RUN:
         begin
            reset_n_d = 1'b1;
            if (trip)
            begin
               st_d = WWDC_ST_PULSE;
               pulse_d = 5'(`WWDC_RST_CYC - 1);
               reset_n_d = 1'b0; // [RULE_03]
               wdg_rst_d = 1'b1;
            end
         end
         WWDC_ST_PULSE:
         begin
            if (pulse_q == 5'h0)
            begin
               // Device reset restores activation, counter and prescaler; options and timebase keep their values
               st_d = WWDC_ST_RUN;
               reset_n_d = 1'b1;
               act_d = 1'b0; // [RULE_06]
               cnt_d = 7'(`WWDC_CTRL_RST); // [RULE_17]
               presc_d = '0;
            end
            else
               pulse_d = pulse_q - 5'h01;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         act_q <= 1'b0; // [RULE_17]
         cnt_q <= 7'h7F;
         presc_q <= '0;
         halt_opt_q <= 1'b0;
         hw_opt_q <= 1'b0;
         tb_q <= 2'b00;
         wdg_rst_q <= 1'b0;
         st_q <= WWDC_ST_RUN;
         pulse_q <= 5'h00;
         reset_n_q <= 1'b1;
      end
      else
      begin
         act_q <= act_d;
         cnt_q <= cnt_d;
         presc_q <= presc_d;
         halt_opt_q <= halt_opt_d;
         hw_opt_q <= hw_opt_d;
         tb_q <= tb_d;
         wdg_rst_q <= wdg_rst_d;
         st_q <= st_d;
         pulse_q <= pulse_d;
         reset_n_q <= reset_n_d;
      end
   end

   // ----------------------------------------
   // Timeout bounds for the loaded step count
   // ----------------------------------------
   wwdc_tbconst_s tbc;
   always_comb
   begin
      unique case (wwdc_tb_e'(tb_q))
         WWDC_TB_2MS: tbc = '{high_c: `WWDC_TB0_HIGH, low_c: `WWDC_TB0_LOW}; // [RULE_10]
         WWDC_TB_4MS: tbc = '{high_c: `WWDC_TB1_HIGH, low_c: `WWDC_TB1_LOW}; // [RULE_10]
         WWDC_TB_10MS: tbc = '{high_c: `WWDC_TB2_HIGH, low_c: `WWDC_TB2_LOW}; // [RULE_10]
         WWDC_TB_25MS: tbc = '{high_c: `WWDC_TB3_HIGH, low_c: `WWDC_TB3_LOW}; // [RULE_10]
      endcase
   end

   // Bounds are in oscillator periods; a sequential divider would save area but cost latency
   logic [5:0] loaded_step_count;
   logic [6:0] q4, hq;
   logic [23:0] base_min, base_max, adj, tmin, tmax;
   assign loaded_step_count = cnt_q[5:0];
   assign hq = tbc.high_c >> 2; // [RULE_14]
   assign q4 = 7'((9'({loaded_step_count, 2'b00})) / 9'(tbc.high_c)); // [RULE_14]
   assign base_min = 24'((32'(tbc.low_c) + `WWDC_MIN_OFFS) * `WWDC_LSB_MUL);
   assign base_max = 24'(`WWDC_PRESC_PERIODS);
   assign adj = 24'(`WWDC_PRESC_PERIODS * (32'(loaded_step_count) - 32'(q4))
      + (`WWDC_ADJ_OFFS + 32'(tbc.low_c)) * `WWDC_LSB_MUL * 32'(q4));
   always_comb
   begin
      tmin = base_min + adj; // [RULE_12]
      tmax = base_max + adj; // [RULE_13]
      if (7'(loaded_step_count) < hq)
         tmin = base_min + 24'(`WWDC_PRESC_PERIODS * 32'(loaded_step_count));
      if (7'(loaded_step_count) <= hq)
         tmax = base_max + 24'(`WWDC_PRESC_PERIODS * 32'(loaded_step_count));
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   logic [7:0] rdata_q, rdata_d;
   logic active_q;
   always_comb
   begin
      rdata_d = 8'h00;
      if (bus.rd)
      begin
         unique case (bus.addr)
            `WWDC_ADDR_CTRL: rdata_d = {act_q, cnt_q};
            `WWDC_ADDR_CFG: rdata_d = {4'h0, tb_q, hw_opt_q, halt_opt_q};
            `WWDC_ADDR_STAT: rdata_d = {6'h00, wdg_rst_q, eff_act};
            `WWDC_ADDR_TMIN: rdata_d = tmin[21:14];
            `WWDC_ADDR_TMAX: rdata_d = tmax[21:14];
            default: rdata_d = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_q <= 8'h00;
         active_q <= 1'b0;
      end
      else
      begin
         rdata_q <= rdata_d;
         active_q <= eff_act;
      end
   end
   assign bus_rdata = rdata_q;
   assign reset_out_n = reset_n_q;
   assign watchdog_active = active_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Reset pulse width, counted here because a property repetition has to stay short
   logic [5:0] low_len_q, low_len_d;
   always_comb
   begin
      low_len_d = 6'h00;
      if (!reset_out_n)
         low_len_d = low_len_q + 6'h01;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         low_len_q <= 6'h00;
      else
         low_len_q <= low_len_d;
   end

   sequence s_trip_cnt;
      osc_edge && !ctrl_wr && presc_q == 14'h3FFF && cnt_q == 7'h40 && eff_act && st_q == WWDC_ST_RUN;
   endsequence
   sequence s_step_due;
      osc_edge && !ctrl_wr && presc_q == 14'h3FFF && st_q == WWDC_ST_RUN;
   endsequence
   sequence s_step_wait;
      osc_edge && !ctrl_wr && presc_q != 14'h3FFF && st_q == WWDC_ST_RUN;
   endsequence
   sequence s_pulse_end;
      st_q == WWDC_ST_PULSE && pulse_q == 5'h00;
   endsequence
   sequence s_pulse_low;
      !reset_out_n [*8];
   endsequence

   // Reset pulse
   a_timeout_reset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
      s_trip_cnt |=> !reset_out_n)
      else $error("Timeout did not pull reset");
   a_pulse_width: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
      $fell(reset_out_n) |-> s_pulse_low)
      else $error("Reset pulse too short");
   a_pulse_ends: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
      $fell(reset_out_n) |-> ##[1:30] reset_out_n)
      else $error("Reset pulse never ends");
   a_pulse_len: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_03]
      $rose(reset_out_n) |-> low_len_q == 6'(`WWDC_RST_CYC))
      else $error("Reset pulse length wrong");
   a_pulse_restore: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06] [RULE_17]
      s_pulse_end |=> cnt_q == 7'h7F && !act_q && reset_out_n)
      else $error("Pulse end did not restore state");
   a_force_reset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_07]
      ctrl_wr && bus.wdata[7] && !bus.wdata[6] && st_q == WWDC_ST_RUN |=> !reset_out_n)
      else $error("Forced reset missing");
   a_halt_reset: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_08]
      halt_edge && eff_act && halt_opt_q && st_q == WWDC_ST_RUN |=> !reset_out_n)
      else $error("Halt reset missing");
   a_inactive_safe: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_04]
      !eff_act && !ctrl_wr && st_q == WWDC_ST_RUN |=> reset_out_n)
      else $error("Reset while inactive");

   // Counter and prescaler
   a_count_step: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01] [RULE_04]
      s_step_due |=> cnt_q == $past(cnt_q) - 7'h01 && presc_q == 14'h0000)
      else $error("Counter did not step");
   a_presc_step: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
      s_step_wait |=> presc_q == $past(presc_q) + 14'h0001 && $stable(cnt_q))
      else $error("Prescaler did not advance");
   a_count_hold: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_01]
      !osc_edge && !ctrl_wr && st_q == WWDC_ST_RUN |=> $stable(cnt_q) && $stable(presc_q))
      else $error("Counter moved without a tick");
   a_write_load: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_18]
      ctrl_wr && st_q == WWDC_ST_RUN |=> cnt_q == $past(bus.wdata[6:0]) && presc_q == 14'h0000)
      else $error("Write did not load");
   a_bounds_order: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_09] [RULE_12] [RULE_13]
      tmin <= tmax)
      else $error("Minimum timeout above maximum");

   // Activation
   a_act_sticky: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_06]
      act_q && st_q == WWDC_ST_RUN |=> act_q)
      else $error("Activation cleared");
   a_hw_active: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
      hw_opt_q |-> ##1 watchdog_active)
      else $error("Hardware option not active");
   a_active_follow: assert property (@(posedge clk) disable iff (!rst_n) // [RULE_16]
      watchdog_active == $past(eff_act))
      else $error("Active flag does not follow");
endmodule
`default_nettype wire

// [verification/windowed_watchdog_downcounter_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "wwdc_defs.svh"
module windowed_watchdog_downcounter_bench;
   import wwdc_pkg::*;
   logic clk, rst_n, osc2_tick, halt_exec, bus_wr, bus_rd, reset_out_n, watchdog_active;
   logic [7:0] bus_addr, bus_wdata, bus_rdata;
   int num_errors, samples_checked, lows, l0;
   int hi_c[4] = '{4, 8, 20, 49};
   int lo_c[4] = '{59, 53, 35, 54};
   int cnts[3] = '{0, 1, 63};
   wwdc_watchdog uut (.clk(clk), .rst_n(rst_n), .osc2_tick(osc2_tick), .halt_exec(halt_exec),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .reset_out_n(reset_out_n), .watchdog_active(watchdog_active));
   // ----------------------------------------
   // Clock, monitors and helpers
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk)
      if (reset_out_n === 1'b0)
         lows++;
   task automatic results();
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      #1;
      chk(nm, exp, bus_rdata);
   endtask
   // Each prescaler tick is a full high-low period of the divided clock pin
   task automatic ticks(input int n, input int s);
      repeat (n)
      begin
         @(posedge clk);
         osc2_tick <= 1'b1;
         @(posedge clk);
         osc2_tick <= 1'b0;
      end
      repeat (s) @(posedge clk);
   endtask
   // Bounded waits; a missing pulse shows up as a wrong length
   task automatic pulse();
      int w;
      int n;
      w = 0;
      n = 0;
      // Step past the current edge, so a pulse launched on it is counted in full
      #1;
      while (reset_out_n !== 1'b0 && w < 200)
      begin
         @(posedge clk);
         #1;
         w++;
      end
      while (reset_out_n === 1'b0 && n < 200)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("pulse_len", 8'h14, 8'(n));
   endtask
   function automatic logic [7:0] tlim(input int c, input int tb, input bit mx);
      int k;
      int t;
      k = 4 * c / hi_c[tb];
      t = mx ? 16384 : (lo_c[tb] + 128) * 64;
      if (mx ? (c <= hi_c[tb] / 4) : (c < hi_c[tb] / 4))
         t = t + 16384 * c;
      else
         t = t + 16384 * (c - k) + (192 + lo_c[tb]) * 64 * k;
      return t[21:14];
   endfunction
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      rst_n = 1'b0;
      osc2_tick = 1'b0;
      halt_exec = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      num_errors = 0;
      samples_checked = 0;
      lows = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(`WWDC_ADDR_CTRL, 8'h7F, "ctrl");
      chk("active", 8'h00, {7'h00, watchdog_active});
      rd(8'h05, 8'h00, "unmapped");
      $display("test reset done");
      foreach (cnts[i])
      begin
         wr(`WWDC_ADDR_CTRL, 8'h40 | 8'(cnts[i]));
         for (int tb = 0; tb < 4; tb++)
         begin
            wr(`WWDC_ADDR_CFG, {4'h0, 2'(tb), 2'b00});
            rd(`WWDC_ADDR_CFG, {4'h0, 2'(tb), 2'b00}, "cfg");
            rd(`WWDC_ADDR_TMIN, tlim(cnts[i], tb, 1'b0), "tmin");
            rd(`WWDC_ADDR_TMAX, tlim(cnts[i], tb, 1'b1), "tmax");
         end
      end
      $display("test timeout bounds done");
      // Inactive: counter still runs, no reset leaves the block
      l0 = lows;
      wr(`WWDC_ADDR_CTRL, 8'h41);
      ticks(16383, 6);
      rd(`WWDC_ADDR_CTRL, 8'h41, "ctrl_early");
      ticks(1, 6);
      rd(`WWDC_ADDR_CTRL, 8'h40, "ctrl_dec");
      chk("no_reset", 8'h00, 8'(lows - l0));
      $display("test free run done");
      wr(`WWDC_ADDR_CTRL, 8'hC0);
      repeat (3) @(posedge clk);
      #1;
      chk("active", 8'h01, {7'h00, watchdog_active});
      wr(`WWDC_ADDR_CTRL, 8'h7F);
      rd(`WWDC_ADDR_CTRL, 8'hFF, "ctrl_sticky");
      rd(`WWDC_ADDR_STAT, 8'h01, "stat_act");
      wr(`WWDC_ADDR_CTRL, 8'hC0);
      ticks(16384, 0);
      pulse();
      rd(`WWDC_ADDR_CTRL, 8'h7F, "ctrl_after");
      rd(`WWDC_ADDR_STAT, 8'h02, "stat_wdrst");
      chk("active", 8'h00, {7'h00, watchdog_active});
      $display("test timeout reset done");
      wr(`WWDC_ADDR_CTRL, 8'h80);
      pulse();
      $display("test forced reset done");
      wr(`WWDC_ADDR_CFG, 8'h01);
      // HALT while inactive must not reset
      l0 = lows;
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      repeat (6) @(posedge clk);
      chk("halt_inactive", 8'h00, 8'(lows - l0));
      wr(`WWDC_ADDR_CTRL, 8'hC0);
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      pulse();
      $display("test halt reset done");
      // Hardware option is sticky, so it is left to the very end
      wr(`WWDC_ADDR_CFG, 8'h02);
      repeat (3) @(posedge clk);
      #1;
      chk("active_hw", 8'h01, {7'h00, watchdog_active});
      rd(`WWDC_ADDR_STAT, 8'h03, "stat_hw");
      wr(`WWDC_ADDR_CTRL, 8'h3F);
      pulse();
      rd(`WWDC_ADDR_STAT, 8'h03, "stat_hw_after");
      $display("test hardware option done");
      results();
   end
   initial
   begin
      repeat (100000) @(posedge clk);
      num_errors++;
      results();
   end
endmodule
`default_nettype wire
